// ---- pport_pins.v ----
// Parallel port pin mapping with AHB-Lite register slave
`timescale 1ns/1ps
`include "pport_consts.vh"

// Operation
// - Strobe pin is inverse of control bit0
// - Status bit7 reads inverted busy input
// - Status bit6 reads acknowledge input directly
// - Status bit5 reads paper-out input directly
// - Status bit4 reads printer-powered input directly
// - Status bit3 reads fault input directly
// - Eight-line bidirectional port data bus
// - Enhanced mode stretches host cycle via ready
// - Enhanced modes pulse shareable interrupt low
// - Select pin is inverse of control bit3
// - Init pin equals control bit2
// - Autofeed pin is inverse of control bit1
module pport_pins #(
    parameter WAIT_W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output wire print_strobe_n,
    output wire printer_select_out_n,
    output wire printer_init_n,
    output wire line_feed_request_n,
    input wire printer_busy,
    input wire printer_ack_n,
    input wire paper_out,
    input wire printer_powered,
    input wire printer_fault_in_n,
    input wire [7:0] port_data_lines_in,
    output reg [7:0] port_data_lines_out,
    output wire [7:0] port_data_lines_oe,
    output wire host_ready_out,
    output wire host_ready_oe,
    output wire share_irq_out,
    output wire share_irq_oe,
    output wire irq
);

    // ==================================================
    // Synchronisers
    reg busy_q1;
    reg busy_q2;
    reg ack_q1;
    reg ack_q2;
    reg paper_q1;
    reg paper_q2;
    reg powered_q1;
    reg powered_q2;
    reg fault_q1;
    reg fault_q2;
    reg [7:0] pd_sync1;
    reg [7:0] pd_sync2;
    // Both stages reset to the idle level of each pin
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q1 <= 1'b0;
            ack_q1 <= 1'b1;
            paper_q1 <= 1'b0;
            powered_q1 <= 1'b1;
            fault_q1 <= 1'b1;
            pd_sync1 <= 8'h00;
        end else begin
            busy_q1 <= printer_busy;
            ack_q1 <= printer_ack_n;
            paper_q1 <= paper_out;
            powered_q1 <= printer_powered;
            fault_q1 <= printer_fault_in_n;
            pd_sync1 <= port_data_lines_in;
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q2 <= 1'b0;
            ack_q2 <= 1'b1;
            paper_q2 <= 1'b0;
            powered_q2 <= 1'b1;
            fault_q2 <= 1'b1;
            pd_sync2 <= 8'h00;
        end else begin
            busy_q2 <= busy_q1;
            ack_q2 <= ack_q1;
            paper_q2 <= paper_q1;
            powered_q2 <= powered_q1;
            fault_q2 <= fault_q1;
            pd_sync2 <= pd_sync1;
        end
    end
    wire busy_s = busy_q2;
    wire ack_s = ack_q2;
    wire paper_s = paper_q2;
    wire powered_s = powered_q2;
    wire fault_s = fault_q2;

    // Status byte, low three bits read zero
    wire [7:0] status_val;
    assign status_val[7] = ~busy_s;
    assign status_val[6] = ack_s;
    assign status_val[5] = paper_s;
    assign status_val[4] = powered_s;
    assign status_val[3] = fault_s;
    assign status_val[2:0] = 3'h0;

    // ==================================================
    // Registers
    reg [7:0] control;
    reg [1:0] mode;
    reg [3:0] irq_status;
    reg [3:0] irq_enable;
    reg [WAIT_W-1:0] wait_cycles;
    reg ack_d;
    reg fault_d;
    reg paper_d;

    // ==================================================
    // Bus address phase capture
    function hit;
        input [11:0] a;
        input [11:0] off;
        begin
            hit = (a == off);
        end
    endfunction
    reg ph_valid;
    reg ph_write;
    reg [11:0] ph_addr;
    reg [WAIT_W-1:0] stretch;
    wire addr_take = hsel && hready && htrans[1];
    wire enh_mode = (mode == `MODE_EPP);
    wire ph_port = hit(ph_addr, `OFF_DATA);
    wire port_access = ph_valid && enh_mode && ph_port;
    wire stretching = port_access && (stretch != {WAIT_W{1'b0}});

    // ==================================================
    // Bus response
    assign hreadyout = !stretching;
    assign hresp = 1'b0;
    // Ready pin held low while a port access is stretched
    assign host_ready_out = 1'b0;
    assign host_ready_oe = stretching;

    wire wr_now = ph_valid && ph_write && !stretching;
    wire wait_done = port_access && (stretch == {{(WAIT_W-1){1'b0}}, 1'b1});

    // ==================================================
    // Event edge detectors
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_d <= 1'b1;
            fault_d <= 1'b1;
            paper_d <= 1'b0;
        end else begin
            ack_d <= ack_s;
            fault_d <= fault_s;
            paper_d <= paper_s;
        end
    end
    wire ev_ack = ack_d && !ack_s;
    wire ev_fault = fault_d && !fault_s;
    wire ev_paper = !paper_d && paper_s;
    wire [3:0] events = {wait_done, ev_paper, ev_fault, ev_ack};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
            stretch <= {WAIT_W{1'b0}};
        end else if (!stretching) begin
            ph_valid <= addr_take;
            ph_write <= hwrite;
            ph_addr <= haddr;
            stretch <= wait_cycles;
        end else begin
            stretch <= stretch - {{(WAIT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= `CTL_RESET;
            mode <= `MODE_STD;
            port_data_lines_out <= 8'h00;
        end else begin
            if (wr_now) begin
                case (ph_addr)
                    `OFF_DATA: port_data_lines_out <= hwdata[7:0];
                    `OFF_CONTROL: control <= hwdata[7:0];
                    `OFF_MODE: mode <= hwdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    // Interrupt enable and wait length
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_enable <= 4'h0;
        end else if (wr_now && hit(ph_addr, `OFF_IRQ_ENABLE)) begin
            irq_enable <= hwdata[3:0];
        end
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cycles <= `WAIT_DEFAULT;
        end else if (wr_now && hit(ph_addr, `OFF_WAIT)) begin
            wait_cycles <= hwdata[WAIT_W-1:0];
        end
    end

    // ==================================================
    // Sticky status, set wins over clear
    wire [3:0] clr = (wr_now && hit(ph_addr, `OFF_IRQ_CLEAR)) ? hwdata[3:0] : 4'h0;
    reg [3:0] next_irq_status;
    always @* begin
        next_irq_status = irq_status & ~clr;
        next_irq_status = next_irq_status | events;
    end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end
    wire [3:0] irq_live = irq_status & irq_enable;
    assign irq = |irq_live;

    // ==================================================
    // Read data
    function [31:0] pad8;
        input [7:0] b;
        begin
            pad8 = {24'h000000, b};
        end
    endfunction
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_take && !hwrite && !stretching) begin
            case (haddr)
                `OFF_DATA: hrdata <= pad8(pd_sync2);
                `OFF_STATUS: hrdata <= pad8(status_val);
                `OFF_CONTROL: hrdata <= pad8(control);
                `OFF_MODE: hrdata <= {30'h00000000, mode};
                `OFF_IRQ_STATUS: hrdata <= {28'h0000000, irq_status};
                `OFF_IRQ_ENABLE: hrdata <= {28'h0000000, irq_enable};
                `OFF_WAIT: hrdata <= {{(32-WAIT_W){1'b0}}, wait_cycles};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // ==================================================
    // Control pins
    assign print_strobe_n = ~control[`CTL_STROBE];
    assign line_feed_request_n = ~control[`CTL_AUTOFEED];
    assign printer_init_n = control[`CTL_INIT];
    assign printer_select_out_n = ~control[`CTL_SELECT];
    // Drive data lines unless reverse direction chosen outside standard mode
    wire reverse_dir = (mode != `MODE_STD) && control[`CTL_DIR];
    assign port_data_lines_oe = reverse_dir ? 8'h00 : 8'hff;

    // ==================================================
    // Shareable interrupt pulse
    reg irq_d;
    reg [7:0] pulse_cnt;
    wire irq_rise = irq && !irq_d;
    wire shared_mode = mode[1];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_d <= 1'b0;
            pulse_cnt <= 8'h00;
        end else begin
            irq_d <= irq;
            if (irq_rise && shared_mode) begin
                pulse_cnt <= `IRQ_PULSE_CYC;
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end
    assign share_irq_out = 1'b0;
    assign share_irq_oe = shared_mode && (pulse_cnt != 8'h00);

endmodule // pport_pins

// ---- pport_consts.vh ----
// Constants for the parallel port pin-mapping block
`ifndef PPORT_CONSTS_VH
`define PPORT_CONSTS_VH
// ==================================================
// Register byte offsets
`define OFF_DATA 12'h000
`define OFF_STATUS 12'h004
`define OFF_CONTROL 12'h008
`define OFF_MODE 12'h00c
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_ENABLE 12'h014
`define OFF_IRQ_CLEAR 12'h018
`define OFF_WAIT 12'h01c
// ==================================================
// Control bits
`define CTL_STROBE 0
`define CTL_AUTOFEED 1
`define CTL_INIT 2
`define CTL_SELECT 3
`define CTL_IRQ_EN 4
`define CTL_DIR 5
`define CTL_RESET 8'h04
// ==================================================
// Status bits
`define ST_ERROR 3
`define ST_POWERED 4
`define ST_PAPER 5
`define ST_ACK 6
`define ST_BUSY 7
// ==================================================
// Modes
`define MODE_STD 2'h0
`define MODE_BIDIR 2'h1
`define MODE_EPP 2'h2
`define MODE_ECP 2'h3
// ==================================================
// Interrupt events
`define EV_ACK 0
`define EV_FAULT 1
`define EV_PAPER 2
`define EV_WAIT_TIMEOUT 3
// ==================================================
// Timing
`define IRQ_PULSE_NS 500
`define IRQ_PULSE_CYC 8'h3f
`define WAIT_DEFAULT 8'h04
`endif

// ---- pport_pins_monitor.sv ----
// Assertion checker for the parallel port pin block
`timescale 1ns/1ps
module pport_pins_monitor (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire print_strobe_n,
    input wire printer_select_out_n,
    input wire printer_init_n,
    input wire line_feed_request_n,
    input wire printer_busy,
    input wire host_ready_oe,
    input wire share_irq_oe
);
    // ==================================================
    // Control write seen in its data phase
    reg wc;
    wire take = hsel && hreadyout && htrans[1];
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wc <= 1'b0;
        else
            wc <= take && hwrite && haddr == 12'h008;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_strobe_map: assert property (wc |=> print_strobe_n == !$past(hwdata[0]))
        else $error("strobe pin");
    a_select_map: assert property (wc |=> printer_select_out_n == !$past(hwdata[3]))
        else $error("select pin");
    a_init_map: assert property (wc |=> printer_init_n == $past(hwdata[2]))
        else $error("init pin");
    a_feed_map: assert property (wc |=> line_feed_request_n == !$past(hwdata[1]))
        else $error("feed pin");
    a_irq_hold: assert property ($rose(share_irq_oe) |-> share_irq_oe [*8])
        else $error("irq pulse short");
    a_irq_release: assert property ($rose(share_irq_oe) |-> ##[60:66] !share_irq_oe)
        else $error("irq not released");
    a_ready_stretch: assert property (host_ready_oe |-> !hreadyout)
        else $error("ready pin");
    a_busy_sync: assert property ($stable(printer_busy) [*4] ##0 (take && !hwrite &&
        haddr == 12'h004) |=> hrdata[7] == !$past(printer_busy)) else $error("busy bit");
endmodule // pport_pins_monitor
bind pport_pins pport_pins_monitor pport_pins_monitor_inst (.*);

// ---- printer_model.sv ----
// Printer at the far end of the cable
`timescale 1ns/1ps
module printer_model #(
    parameter DLY = 20
) (
    input wire clk,
    input wire strobe_n,
    input wire [7:0] pd,
    output reg busy = 1'b0,
    output reg ack_n = 1'b1,
    output reg [7:0] latched = 8'h00
);
    reg s_d = 1'b1;
    integer n = 0;
    always @(posedge clk) begin
        s_d <= strobe_n;
        if (s_d && !strobe_n) begin
            latched <= pd;
            busy <= 1'b1;
            n <= DLY;
        end else if (n > 1) begin
            n <= n - 1;
        end else if (n == 1) begin
            busy <= 1'b0;
            ack_n <= 1'b0;
            n <= 0;
        end else begin
            ack_n <= 1'b1;
        end
    end
endmodule // printer_model

// ---- tb_top.sv ----
// Testbench for the parallel port pin block
`timescale 1ns/1ps
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, r;
    logic paper_out = 1'b0, printer_powered = 1'b1, printer_fault_in_n = 1'b1;
    wire [31:0] hrdata;
    wire hreadyout, print_strobe_n, printer_select_out_n, printer_init_n, line_feed_request_n;
    wire printer_busy, printer_ack_n, irq, host_ready_oe, share_irq_oe;
    wire [7:0] pd_out, pd_oe, latched;
    wire [7:0] pd = (pd_oe & pd_out) | (~pd_oe & ~latched);
    integer err_total = 0, samples_checked = 0, stalls;
    always #4 hclk = ~hclk;
    pport_pins pport_pins_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .print_strobe_n,
        .printer_select_out_n, .printer_init_n, .line_feed_request_n, .printer_busy,
        .printer_ack_n, .paper_out, .printer_powered, .printer_fault_in_n,
        .port_data_lines_in(pd), .port_data_lines_out(pd_out), .port_data_lines_oe(pd_oe),
        .host_ready_out(), .host_ready_oe, .share_irq_out(), .share_irq_oe, .irq);
    printer_model printer_model_inst (.clk(hclk), .strobe_n(print_strobe_n), .pd(pd),
        .busy(printer_busy), .ack_n(printer_ack_n), .latched(latched));
    // ==================================================
    // Shared tasks
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, v);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        stalls = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            stalls++;
            @(posedge hclk);
        end
        r = hrdata;
        if (n >= 50) begin
            err_total++;
            wrap_up;
        end
    endtask
    // ==================================================
    // Scenarios
    task t_ctrl;
        logic [3:0] v;
        for (int i = 0; i < 4; i++) begin
            v = 4'h1 << i;
            bus(1, 12'h008, {28'h0, v});
            @(posedge hclk);
            chk("pins", {~v[0], ~v[3], v[2], ~v[1]}, {print_strobe_n, printer_select_out_n,
                printer_init_n, line_feed_request_n});
        end
    endtask
    task t_print;
        bus(1, 12'h000, 32'h5a);
        bus(1, 12'h008, 32'h05);
        bus(1, 12'h008, 32'h04);
        repeat (4) @(posedge hclk);
        bus(0, 12'h004, 0);
        chk("busy bit", 0, r[7]);
        repeat (40) @(posedge hclk);
        chk("latched", 32'h5a, latched);
        bus(0, 12'h004, 0);
        chk("idle bits", 32'h3, r[7:6]);
        bus(1, 12'h00c, 1);
        bus(1, 12'h008, 32'h24);
        repeat (4) @(posedge hclk);
        bus(0, 12'h000, 0);
        chk("data in", 32'ha5, r[7:0]);
        bus(1, 12'h008, 32'h04);
    endtask
    task t_status;
        paper_out <= 1'b1;
        printer_powered <= 1'b0;
        printer_fault_in_n <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(0, 12'h004, 0);
        chk("status a", 32'he0, r[7:0]);
        paper_out <= 1'b0;
        printer_powered <= 1'b1;
        printer_fault_in_n <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(0, 12'h004, 0);
        chk("status b", 32'hd8, r[7:0]);
    endtask
    task t_irq;
        chk("irq masked", 0, irq);
        bus(0, 12'h010, 0);
        chk("events", 32'h7, r[3:0]);
        bus(1, 12'h018, 32'h7);
        bus(1, 12'h014, 32'h4);
        bus(1, 12'h00c, 32'h2);
        paper_out <= 1'b1;
        repeat (6) @(posedge hclk);
        chk("irq set", 1, irq);
        repeat (70) @(posedge hclk);
        bus(1, 12'h018, 32'h4);
        @(posedge hclk);
        chk("irq clear", 0, irq);
    endtask
    task t_epp;
        bus(0, 12'h000, 0);
        chk("stalls", 4, stalls);
        bus(1, 12'h00c, 0);
        bus(0, 12'h100, 0);
        chk("unmapped", 0, r);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_ctrl;
        t_print;
        t_status;
        t_irq;
        t_epp;
        wrap_up;
    end
endmodule // tb_top
